// ---- core/hsar_regs.svh ----
`ifndef HSAR_REGS_SVH
`define HSAR_REGS_SVH
`define HSAR_MODE_AUTO 2'h0
`define HSAR_MODE_NONAUTO 2'h1
`define HSAR_MODE_TRANSP1 2'h2
`define HSAR_MODE_OTHER 2'h3
`define HSAR_GROUP_ADDR_A 8'hFC
`define HSAR_GROUP_ADDR_B 8'hFE
`define HSAR_CTL_RR_RESP 8'h11
`define HSAR_CTL_I_RESP 8'h10
`define HSAR_POLL_BIT 4
`define HSAR_CMD_PREP_HI 4'hA
`define HSAR_CMD_ACK_LO 8'hD0
`define HSAR_CMD_ACK_HI 8'hEF
`define HSAR_STAT_CRC_BIT 5
`define HSAR_STAT_ABORT_BIT 4
`define HSAR_FIFO_DEPTH 16
`define HSAR_FIFO_AW 4
`endif

// ---- core/hsar_pkg.sv ----
package hsar_pkg;
  typedef enum logic [1:0]
  {
    HSAR_FT_I = 2'b00,
    HSAR_FT_RR = 2'b01,
    HSAR_FT_EXT = 2'b11
  } hsar_ftype_e;
  typedef enum logic [1:0]
  {
    HSAR_RSP_NONE = 2'b00,
    HSAR_RSP_RR = 2'b01,
    HSAR_RSP_IDATA = 2'b10,
    HSAR_RSP_CTRL = 2'b11
  } hsar_resp_e;
  typedef struct packed
  {
    logic [7:0] data;
    logic last;
  } hsar_word_s;
  typedef struct packed
  {
    hsar_resp_e kind;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic two_byte;
    logic [7:0] ctrl;
  } hsar_resp_s;
endpackage

// ---- core/hsar_fifo.sv ----
`timescale 1ns/1ns
module hsar_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // sync reset, low
  input wire logic i_flush, // drop contents
  input wire logic i_in_valid, // write request
  output logic o_in_ready, // space free
  input wire logic [WIDTH-1:0] i_in_data, // write data
  output logic o_out_valid, // data present
  input wire logic i_out_ready, // reader takes
  output logic [WIDTH-1:0] o_out_data // head word
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire do_wr = i_in_valid && !full;
  wire do_rd = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n || i_flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (do_wr)
        wr_q <= wr_q + 1'b1;
      if (do_rd)
        rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (do_wr)
      mem_q[wr_q[AW-1:0]] <= i_in_data;
  end
endmodule

// ---- core/hsar_responder.sv ----
// Functional notes
// RULE_01: auto secondary mode when mode select equals 00.
// RULE_02: 1/2-byte addresses, any length, auto RR/I responses, window one.
// RULE_03: non-auto low match and transparent-1 high match store transparently.
// RULE_04: auto protocol only on first compare values; others stored raw.
// RULE_05: frames with no valid address are skipped silently.
// RULE_06: control bit0=0 I, bits 01 RR, 11 extended; bit4 poll.
// RULE_07: extended frame raises interrupt, stores nothing, keeps control byte.
// RULE_08: RR frames handled in hardware, never stored.
// RULE_09: RR poll answers I-frame if direct data loaded, else RR.
// RULE_10: RR without poll clears transmit queue, pool-ready irq, no answer.
// RULE_11: repeated polls allowed; auto-repeat resends, else repeat irq. Code resends in both cases.
// RULE_12: software keeps auto-repeat off for frames over 32 bytes.
// RULE_13: auto-repeat with DMA gives no legacy-compatible control response.
// RULE_14: I-frame first info byte is the command byte.
// RULE_15: commands 00-9F,B0-CF,F0-FF stored, irqs, answer if polled.
// RULE_16: D0-EF after prepared data: drop, flush tx, pool-ready, answer.
// RULE_17: D0-EF without prepared data: drop, no irq, answer if polled.
// RULE_18: software interprets command bytes of stored I-frames.
// RULE_19: bad CRC or abort I-frames stored, status flags set, no answer.
// RULE_20: transmit only after RR or I-frame with poll set.
// RULE_21: A0-AF after prepared data sends I-frame with queue contents.
// RULE_22: RR answer carries tx address and control 11.
// RULE_23: I answer carries tx address, control 10, queue data.
`timescale 1ns/1ns
`include "hsar_regs.svh"
module hsar_responder (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // sync reset, low
  input wire logic i_op_mode_sel_hi, // mode select bit 1
  input wire logic i_op_mode_sel_lo, // mode select bit 0
  input wire logic i_two_byte_addr, // 2-byte address field
  input wire logic [7:0] i_low_addr_compare_a, // low compare a
  input wire logic [7:0] i_low_addr_compare_b, // low compare b
  input wire logic [7:0] i_high_addr_compare_a, // high compare a
  input wire logic [7:0] i_high_addr_compare_b, // high compare b
  input wire logic [7:0] i_tx_addr_byte_one, // tx address 1
  input wire logic [7:0] i_tx_addr_byte_two, // tx address 2
  input wire logic i_auto_repeat_enable, // auto repeat
  input wire logic i_send_direct_data_cmd, // direct data loaded pulse
  input wire logic i_send_prepared_data_cmd, // prepared data loaded pulse
  input wire logic i_rx_valid, // rx byte strobe
  output logic o_rx_ready, // queue can accept
  input wire logic [7:0] i_rx_data, // rx byte
  input wire logic i_rx_end, // frame end pulse
  input wire logic i_rx_crc_err, // crc bad at end
  input wire logic i_rx_abort, // abort at end
  output logic o_rq_valid, // receive_queue word ready
  input wire logic i_rq_ready, // processor reads
  output hsar_pkg::hsar_word_s o_rq_word, // receive_queue word
  output logic [7:0] o_rx_control_field_reg, // control byte of last extended frame
  output logic o_rx_block_ready_irq, // block ready pulse
  output logic o_rx_message_end_irq, // message end pulse
  output logic o_extended_frame_irq, // extended frame pulse
  output logic o_tx_pool_ready_irq, // pool ready pulse
  output logic o_tx_repeat_irq, // repeat pulse
  output logic o_tx_queue_flush, // clear transmit_queue pulse
  output logic o_resp_valid, // response request pulse
  output hsar_pkg::hsar_resp_s o_resp // response descriptor
);
  import hsar_pkg::*;

  typedef enum logic [2:0]
  {
    HSAR_S_ADDR1 = 3'b000,
    HSAR_S_ADDR2 = 3'b001,
    HSAR_S_CTRL = 3'b010,
    HSAR_S_CMD = 3'b011,
    HSAR_S_DATA = 3'b100,
    HSAR_S_SKIP = 3'b101
  } hsar_state_e;

  function automatic logic in_range(input logic [7:0] v,
    input logic [7:0] lo, input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic hi_match(input logic [7:0] v,
    input logic [7:0] a, input logic [7:0] b);
    hi_match = (v == a) || (v == b) || (v == `HSAR_GROUP_ADDR_A)
      || (v == `HSAR_GROUP_ADDR_B);
  endfunction

  hsar_state_e st_q, st_d;
  logic [7:0] hi_q;
  logic [7:0] ctrl_q;
  logic auto_q; // frame follows auto protocol
  logic store_q; // frame goes to receive_queue
  logic [4:0] cnt_q; // stored bytes since last block irq or frame end
  logic [7:0] ctl_reg_q;
  logic direct_q; // direct data loaded
  logic prep_q; // prepared data loaded
  logic sent_q; // an I-frame went out unacknowledged
  logic pend_q; // stored frame awaits end
  logic cmd_poll_q;
  logic [7:0] cmd_q;
  logic rsp_v_q;
  hsar_resp_s rsp_q;
  logic rpf_q, rme_q, ehc_q, xpr_q, xmr_q, flush_q;
  logic fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic fifo_in_valid;
  logic [8:0] fifo_out;

  wire [1:0] mode = {i_op_mode_sel_hi, i_op_mode_sel_lo};
  wire mode_auto = (mode == `HSAR_MODE_AUTO); // RULE_01
  wire mode_nonauto = (mode == `HSAR_MODE_NONAUTO);
  wire mode_transp1 = (mode == `HSAR_MODE_TRANSP1);
  wire low_a = (i_rx_data == i_low_addr_compare_a);
  wire low_b = (i_rx_data == i_low_addr_compare_b);
  wire hi_ok = hi_match(i_rx_data, i_high_addr_compare_a,
    i_high_addr_compare_b);
  wire hi_first = (hi_q == i_high_addr_compare_a);
  wire is_iframe = !i_rx_data[0]; // RULE_06
  wire is_rr = (i_rx_data[1:0] == 2'b01); // RULE_06
  wire is_ext = (i_rx_data[1:0] == 2'b11); // RULE_06
  wire poll = i_rx_data[`HSAR_POLL_BIT]; // RULE_06
  wire cmd_prep = (i_rx_data[7:4] == `HSAR_CMD_PREP_HI);
  wire cmd_ack = in_range(i_rx_data, `HSAR_CMD_ACK_LO, `HSAR_CMD_ACK_HI);
  wire byte_in = i_rx_valid && o_rx_ready;
  wire frame_bad = i_rx_crc_err || i_rx_abort;

  // stall the link while the receive queue is full
  assign o_rx_ready = fifo_in_ready;
  assign o_rx_control_field_reg = ctl_reg_q;
  assign o_rx_block_ready_irq = rpf_q;
  assign o_rx_message_end_irq = rme_q;
  assign o_extended_frame_irq = ehc_q;
  assign o_tx_pool_ready_irq = xpr_q;
  assign o_tx_repeat_irq = xmr_q;
  assign o_tx_queue_flush = flush_q;
  assign o_resp_valid = rsp_v_q;
  assign o_resp = rsp_q;
  wire rq_v;
  assign o_rq_valid = rq_v;
  assign o_rq_word = hsar_word_s'(fifo_out);

  // status byte appended at frame end marks crc and abort
  wire [7:0] stat_byte = (8'h01 << `HSAR_STAT_CRC_BIT) & {8{i_rx_crc_err}}
    | (8'h01 << `HSAR_STAT_ABORT_BIT) & {8{i_rx_abort}};
  // command byte is stored with its frame, decided as it arrives
  wire wr_data = byte_in && (store_q && st_q == HSAR_S_DATA
    || st_q == HSAR_S_CMD && !cmd_prep && !cmd_ack); // RULE_14 RULE_15
  wire wr_stat = store_q && i_rx_end && pend_q;
  assign fifo_in_valid = wr_data || wr_stat; // RULE_19
  assign fifo_in_data = wr_stat ? {stat_byte, 1'b1} : {i_rx_data, 1'b0};

  hsar_fifo #(
    .WIDTH(9),
    .DEPTH(`HSAR_FIFO_DEPTH),
    .AW(`HSAR_FIFO_AW)
  ) u_rq (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_flush(1'b0),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(rq_v),
    .i_out_ready(i_rq_ready),
    .o_out_data(fifo_out)
  );

  // frame state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      HSAR_S_ADDR1:
        if (byte_in)
          st_d = i_two_byte_addr && !mode_transp1 ? HSAR_S_ADDR2 // RULE_02
            : HSAR_S_CTRL;
      HSAR_S_ADDR2:
        if (byte_in)
          st_d = HSAR_S_CTRL;
      HSAR_S_CTRL:
        if (byte_in)
          st_d = auto_q && is_iframe ? HSAR_S_CMD : HSAR_S_DATA;
      HSAR_S_CMD:
        if (byte_in)
          st_d = HSAR_S_DATA;
      HSAR_S_DATA:
        st_d = HSAR_S_DATA;
      HSAR_S_SKIP:
        st_d = HSAR_S_SKIP;
      default:
        st_d = HSAR_S_ADDR1;
    endcase
    if (i_rx_end)
      st_d = HSAR_S_ADDR1;
  end

  function automatic hsar_resp_s mk_resp(input hsar_resp_e k,
    input logic [7:0] a1, input logic [7:0] a2, input logic two);
    mk_resp.kind = k;
    mk_resp.addr1 = a1;
    mk_resp.addr2 = a2;
    mk_resp.two_byte = two;
    mk_resp.ctrl = (k == HSAR_RSP_RR) ? `HSAR_CTL_RR_RESP // RULE_22
      : `HSAR_CTL_I_RESP; // RULE_23
  endfunction

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      st_q <= HSAR_S_ADDR1;
    else if (byte_in && st_q == HSAR_S_ADDR1 && mode_transp1 && !hi_ok)
      st_q <= HSAR_S_SKIP; // RULE_05
    else
      st_q <= st_d;
  end

  // address decode and frame classification
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      hi_q <= 8'h00;
      ctrl_q <= 8'h00;
      auto_q <= 1'b0;
      store_q <= 1'b0;
      pend_q <= 1'b0;
      ctl_reg_q <= 8'h00;
      cmd_poll_q <= 1'b0;
      cmd_q <= 8'h00;
    end
    else if (byte_in)
    begin
      case (st_q)
        HSAR_S_ADDR1:
        begin
          hi_q <= i_rx_data;
          auto_q <= 1'b0;
          pend_q <= 1'b0;
          if (mode_transp1)
            store_q <= hi_ok; // RULE_03
          else if (!i_two_byte_addr)
          begin
            auto_q <= mode_auto && low_a; // RULE_04
            store_q <= (low_a || low_b) && (mode_nonauto
              || (mode_auto && !low_a)); // RULE_03 RULE_04 RULE_05
          end
          else
            store_q <= 1'b0;
        end
        HSAR_S_ADDR2:
        begin
          auto_q <= mode_auto && hi_first && low_a; // RULE_04
          store_q <= hi_match(hi_q, i_high_addr_compare_a,
            i_high_addr_compare_b) && (low_a || low_b)
            && (mode_nonauto || (mode_auto && !(hi_first && low_a)));
        end
        HSAR_S_CTRL:
        begin
          ctrl_q <= i_rx_data;
          if (auto_q)
          begin
            store_q <= 1'b0; // RULE_08
            if (is_ext)
              ctl_reg_q <= i_rx_data; // RULE_07
          end
          pend_q <= store_q;
        end
        HSAR_S_CMD:
        begin
          cmd_q <= i_rx_data; // RULE_14
          cmd_poll_q <= ctrl_q[`HSAR_POLL_BIT];
          store_q <= !cmd_prep && !cmd_ack; // RULE_15 RULE_16 RULE_17
          pend_q <= !cmd_prep && !cmd_ack;
        end
        default:
          pend_q <= pend_q;
      endcase
    end
    else if (i_rx_end)
      pend_q <= 1'b0;
  end

  wire ctrl_done = byte_in && (st_q == HSAR_S_CTRL) && auto_q;
  wire cmd_done = byte_in && (st_q == HSAR_S_CMD);
  wire end_auto = i_rx_end && auto_q && !ctrl_q[0] && !frame_bad
    && (st_q == HSAR_S_DATA) && cmd_poll_q;
  wire is_prep_cmd = (cmd_q[7:4] == `HSAR_CMD_PREP_HI);
  wire is_ack_cmd = in_range(cmd_q, `HSAR_CMD_ACK_LO, `HSAR_CMD_ACK_HI);

  // transmit side state and responses, window of one frame
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      direct_q <= 1'b0;
      prep_q <= 1'b0;
      sent_q <= 1'b0;
      rsp_v_q <= 1'b0;
      rsp_q <= '0;
      rpf_q <= 1'b0;
      rme_q <= 1'b0;
      ehc_q <= 1'b0;
      xpr_q <= 1'b0;
      xmr_q <= 1'b0;
      flush_q <= 1'b0;
      cnt_q <= 5'h00;
    end
    else
    begin
      rsp_v_q <= 1'b0;
      rpf_q <= 1'b0;
      rme_q <= 1'b0;
      ehc_q <= 1'b0;
      xpr_q <= 1'b0;
      xmr_q <= 1'b0;
      flush_q <= 1'b0;
      if (wr_data)
        cnt_q <= cnt_q + 5'h01;
      if (wr_data && cnt_q == 5'h1F)
        rpf_q <= 1'b1; // RULE_15
      if (wr_stat)
      begin
        rme_q <= 1'b1; // RULE_04 RULE_15
        cnt_q <= 5'h00;
      end
      if (i_send_direct_data_cmd)
        direct_q <= 1'b1;
      if (i_send_prepared_data_cmd)
        prep_q <= 1'b1;
      if (ctrl_done && is_ext)
        ehc_q <= 1'b1; // RULE_07
      if (ctrl_done && is_rr && poll)
      begin
        rsp_v_q <= 1'b1; // RULE_09 RULE_20
        if (direct_q)
        begin
          rsp_q <= mk_resp(HSAR_RSP_IDATA, i_tx_addr_byte_one,
            i_tx_addr_byte_two, i_two_byte_addr);
          sent_q <= 1'b1;
          // repeat poll: hardware resends, plus repeat irq unless auto-repeat
          if (sent_q && !i_auto_repeat_enable)
            xmr_q <= 1'b1; // RULE_11
        end
        else
          rsp_q <= mk_resp(HSAR_RSP_RR, i_tx_addr_byte_one,
            i_tx_addr_byte_two, i_two_byte_addr); // RULE_22
      end
      if (ctrl_done && is_rr && !poll)
      begin
        flush_q <= 1'b1; // RULE_10
        xpr_q <= 1'b1;
        direct_q <= i_send_direct_data_cmd;
        sent_q <= 1'b0;
      end
      if (cmd_done && cmd_ack && prep_q)
      begin
        flush_q <= 1'b1; // RULE_16
        xpr_q <= 1'b1;
        prep_q <= i_send_prepared_data_cmd;
        sent_q <= 1'b0;
      end
      if (end_auto)
      begin
        rsp_v_q <= 1'b1; // RULE_20 RULE_19
        if (is_prep_cmd && prep_q)
        begin
          rsp_q <= mk_resp(HSAR_RSP_IDATA, i_tx_addr_byte_one,
            i_tx_addr_byte_two, i_two_byte_addr); // RULE_21 RULE_23
          sent_q <= 1'b1;
        end
        else
          // control response byte built outside; with dma and
          // auto-repeat it may not match the legacy convention
          rsp_q <= mk_resp(HSAR_RSP_CTRL, i_tx_addr_byte_one,
            i_tx_addr_byte_two, i_two_byte_addr); // RULE_13 RULE_17
      end
    end
  end
endmodule

// ---- testbench/hsar_responder_sva.sv ----
`timescale 1ns/1ns
module hsar_responder_sva
  import hsar_pkg::*;
(
  input wire logic i_clk_sys, // clock
  input wire logic i_rst_n, // sync reset
  input wire logic i_op_mode_sel_hi, // mode hi
  input wire logic i_op_mode_sel_lo, // mode lo
  input wire logic i_two_byte_addr, // 2-byte addr
  input wire logic [7:0] i_low_addr_compare_a, // primary addr
  input wire logic [7:0] i_tx_addr_byte_one, // resp addr
  input wire logic i_rx_valid, // rx strobe
  input wire logic o_rx_ready, // rx ready
  input wire logic [7:0] i_rx_data, // rx byte
  input wire logic i_rx_end, // frame end
  input wire logic i_rx_crc_err, // bad crc
  input wire logic o_resp_valid, // resp pulse
  input wire hsar_pkg::hsar_resp_s o_resp, // resp
  input wire logic o_extended_frame_irq, // ext irq
  input wire logic o_tx_queue_flush, // flush
  input wire logic o_tx_pool_ready_irq, // pool irq
  input wire logic o_rx_message_end_irq // rme irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [1:0] idx_q;
  logic [7:0] a0_q;
  logic acc;
  logic hit;
  assign acc = i_rx_valid && o_rx_ready;
  // control byte of a 1-byte frame to the primary address
  assign hit = acc && idx_q == 2'h1 && a0_q == i_low_addr_compare_a
    && !i_op_mode_sel_hi && !i_op_mode_sel_lo && !i_two_byte_addr;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n || i_rx_end)
      idx_q <= 2'h0;
    else if (acc && idx_q != 2'h3)
      idx_q <= idx_q + 2'h1;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (acc && idx_q == 2'h0)
      a0_q <= i_rx_data;
  end
  a_rr_poll_resp: assert property (hit && i_rx_data[4] &&
    i_rx_data[1:0] == 2'h1 |=> o_resp_valid && o_resp.kind != HSAR_RSP_CTRL)
    else $error("rr poll got no response");
  a_rr_ack_flush: assert property (hit && !i_rx_data[4] &&
    i_rx_data[1:0] == 2'h1 |=> o_tx_queue_flush && o_tx_pool_ready_irq
    && !o_resp_valid) else $error("rr ack effects wrong");
  a_ext_irq_due: assert property (hit && i_rx_data[1:0] == 2'h3
    |-> ##[1:3] o_extended_frame_irq) else $error("no extended irq");
  a_rr_ctrl_val: assert property (o_resp_valid &&
    o_resp.kind == HSAR_RSP_RR |-> o_resp.ctrl == 8'h11)
    else $error("rr response control wrong");
  a_i_ctrl_val: assert property (o_resp_valid &&
    o_resp.kind != HSAR_RSP_RR |-> o_resp.ctrl == 8'h10)
    else $error("i response control wrong");
  a_resp_addr_ok: assert property (o_resp_valid
    |-> o_resp.addr1 == i_tx_addr_byte_one) else $error("response address");
  a_resp_hold: assert property (!o_resp_valid |-> $stable(o_resp))
    else $error("response changed without request");
  a_crc_silent: assert property (i_rx_end && i_rx_crc_err
    |=> !o_resp_valid [*3]) else $error("bad frame answered");
  a_skip_silent: assert property (i_rx_end && i_op_mode_sel_hi
    && i_op_mode_sel_lo |=> !o_rx_message_end_irq [*2])
    else $error("unmatched frame signalled");
endmodule
bind hsar_responder hsar_responder_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_op_mode_sel_hi(i_op_mode_sel_hi), .i_op_mode_sel_lo(i_op_mode_sel_lo),
  .i_two_byte_addr(i_two_byte_addr),
  .i_low_addr_compare_a(i_low_addr_compare_a),
  .i_tx_addr_byte_one(i_tx_addr_byte_one), .i_rx_valid(i_rx_valid),
  .o_rx_ready(o_rx_ready), .i_rx_data(i_rx_data), .i_rx_end(i_rx_end),
  .i_rx_crc_err(i_rx_crc_err), .o_resp_valid(o_resp_valid),
  .o_resp(o_resp), .o_extended_frame_irq(o_extended_frame_irq),
  .o_tx_queue_flush(o_tx_queue_flush),
  .o_tx_pool_ready_irq(o_tx_pool_ready_irq),
  .o_rx_message_end_irq(o_rx_message_end_irq));

// ---- testbench/hsar_gc_model.sv ----
`timescale 1ns/1ns
module hsar_gc_model (
  input wire logic i_clk_sys, // clock
  input wire logic i_rx_ready, // device accepts
  output logic o_rx_valid, // byte strobe
  output logic [7:0] o_rx_data, // byte
  output logic o_rx_end, // frame end
  output logic o_rx_crc_err, // bad crc
  output logic o_rx_abort // aborted
);
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_end = 1'b0;
    o_rx_crc_err = 1'b0;
    o_rx_abort = 1'b0;
  end
  // held until taken; released data is inverted, no pull on the line
  task automatic send_byte(input logic [7:0] b);
    @(negedge i_clk_sys);
    o_rx_valid = 1'b1;
    o_rx_data = b;
    while (i_rx_ready !== 1'b1)
      @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    o_rx_valid = 1'b0;
    o_rx_data = ~b;
  endtask
  task automatic end_frame(input logic c, input logic a);
    @(negedge i_clk_sys);
    o_rx_end = 1'b1;
    o_rx_crc_err = c;
    o_rx_abort = a;
    @(negedge i_clk_sys);
    o_rx_end = 1'b0;
    o_rx_crc_err = 1'b0;
    o_rx_abort = 1'b0;
  endtask
endmodule

// ---- testbench/hsar_responder_bench.sv ----
`timescale 1ns/1ns
module hsar_responder_bench;
  import hsar_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ar = 1'b0;
  logic ddc = 1'b0;
  logic pdc = 1'b0;
  logic rq_rdy = 1'b0;
  logic hold = 1'b0;
  logic [1:0] md = 2'h0;
  logic [7:0] la = 8'h31;
  logic [7:0] lb = 8'h52;
  logic [7:0] ha = 8'h73;
  logic [7:0] hb = 8'h94;
  logic [7:0] tx1 = 8'h00;
  logic [7:0] tx2 = 8'h00;
  logic [7:0] rd, lstat, rxd, creg, hadr;
  logic rxv, rxe, rxc, rxa, rxr, rqv, rsv, rx_message_end_irq, ext, pool, rep, fl, rx_block_ready_irq;
  hsar_word_s rqw;
  hsar_resp_s rsp, rlast;
  int n_errors = 0;
  int n_checks = 0;
  int nw, nrsp, nfl, npool, next, nrme, nrep, nrpf;
  int exq[$];
  bit dd, pd, pold, two;
  always #20 clk = ~clk;
  hsar_responder u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_op_mode_sel_hi(md[1]), .i_op_mode_sel_lo(md[0]),
    .i_two_byte_addr(two), .i_low_addr_compare_a(la),
    .i_low_addr_compare_b(lb), .i_high_addr_compare_a(ha),
    .i_high_addr_compare_b(hb), .i_tx_addr_byte_one(tx1),
    .i_tx_addr_byte_two(tx2), .i_auto_repeat_enable(ar),
    .i_send_direct_data_cmd(ddc), .i_send_prepared_data_cmd(pdc),
    .i_rx_valid(rxv), .o_rx_ready(rxr), .i_rx_data(rxd), .i_rx_end(rxe),
    .i_rx_crc_err(rxc), .i_rx_abort(rxa), .o_rq_valid(rqv),
    .i_rq_ready(rq_rdy), .o_rq_word(rqw), .o_rx_control_field_reg(creg),
    .o_rx_block_ready_irq(rx_block_ready_irq), .o_rx_message_end_irq(rx_message_end_irq),
    .o_extended_frame_irq(ext), .o_tx_pool_ready_irq(pool),
    .o_tx_repeat_irq(rep), .o_tx_queue_flush(fl), .o_resp_valid(rsv),
    .o_resp(rsp));
  hsar_gc_model u_gc (.i_clk_sys(clk), .i_rx_ready(rxr), .o_rx_valid(rxv),
    .o_rx_data(rxd), .o_rx_end(rxe), .o_rx_crc_err(rxc), .o_rx_abort(rxa));
  // reader stalls at random so the queue really backs up
  always @(negedge clk)
    rq_rdy <= hold ? 1'b0 : 1'($urandom);
  always @(posedge clk)
  begin
    if (rst_n === 1'b1)
    begin
      if (rqv === 1'b1 && rq_rdy === 1'b1)
      begin
        nw++;
        if (rqw.last === 1'b1)
          lstat = rqw.data;
        else if (exq.size() == 0)
          chk_n(1, 0);
        else
          chk_v(rqw.data, 8'(exq.pop_front()));
      end
      if (rsv === 1'b1)
        rlast = rsp;
      nrsp += int'(rsv === 1'b1);
      nfl += int'(fl === 1'b1);
      npool += int'(pool === 1'b1);
      next += int'(ext === 1'b1);
      nrme += int'(rx_message_end_irq === 1'b1);
      nrep += int'(rep === 1'b1);
      nrpf += int'(rx_block_ready_irq === 1'b1);
    end
  end
  task automatic test_done;
    $display("errors %0d, checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      n_errors++;
      $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input bit prep);
    @(negedge clk);
    pdc = prep;
    ddc = !prep;
    @(negedge clk);
    pdc = 1'b0;
    ddc = 1'b0;
    pd = pd || prep;
    dd = dd || !prep;
  endtask
  task automatic frame(input logic [1:0] m, input logic [7:0] a, c, d,
    input int nd, input logic [1:0] bad);
    bit ap, tr, st, pl, hi;
    logic [7:0] b;
    int e_rsp, e_fl, e_ext, e_rep;
    hsar_resp_e ek;
    {e_rsp, e_fl, e_ext, e_rep, st} = '0;
    ek = HSAR_RSP_CTRL;
    pl = c[4];
    hi = hadr == ha || hadr == hb || hadr == 8'hFC || hadr == 8'hFE;
    ap = m == 2'h0 && a == la && (!two || hadr == ha);
    tr = !ap && (m == 2'h0 || m == 2'h1) && (a == la || a == lb)
      && (!two || hi) && (m == 2'h1 || two || a == lb)
      || (m == 2'h2 && (a == ha || a == hb || a == 8'hFC || a == 8'hFE));
    if (ap && c[1:0] == 2'h1)
    begin
      e_rsp = int'(pl);
      ek = dd ? HSAR_RSP_IDATA : HSAR_RSP_RR;
      e_rep = int'(pl && dd && pold && !ar);
      e_fl = int'(!pl);
      pold = pl && (pold || dd);
      {dd, pd} = pl ? {dd, pd} : 2'b00;
    end
    else if (ap && c[1:0] == 2'h3)
      e_ext = 1;
    else if (ap && bad != 2'h0)
      st = 1'b1;
    else if (ap && d >= 8'hD0 && d <= 8'hEF)
    begin
      e_fl = int'(pd);
      {dd, pd, pold} = pd ? 3'b000 : {dd, pd, pold};
      e_rsp = int'(pl);
    end
    else if (ap)
    begin
      st = d[7:4] != 4'hA;
      e_rsp = int'(pl);
      ek = (d[7:4] == 4'hA && pd) ? HSAR_RSP_IDATA : HSAR_RSP_CTRL;
    end
    else
      st = tr;
    @(negedge clk);
    md = m;
    {nw, nrsp, nfl, npool, next, nrme, nrep, nrpf} = '0;
    lstat = 8'h00;
    if (two)
      u_gc.send_byte(hadr);
    u_gc.send_byte(a);
    u_gc.send_byte(c);
    for (int i = 0; i < nd; i++)
    begin
      b = d + 8'(i);
      u_gc.send_byte(b);
      if (st)
        exq.push_back(int'(b));
    end
    u_gc.end_frame(bad[1], bad[0]);
    for (int i = 0; i < 300 && rqv !== 1'b0; i++)
      @(negedge clk);
    chk_n(int'(rqv === 1'b0), 1);
    repeat (4) @(negedge clk);
    chk_n(nrsp, e_rsp);
    if (e_rsp != 0)
    begin
      chk_v(8'(rlast.kind), 8'(ek));
      chk_v(rlast.ctrl, ek == HSAR_RSP_RR ? 8'h11 : 8'h10);
      chk_v(rlast.addr1, tx1);
      chk_v(rlast.addr2, tx2);
      chk_v(8'(rlast.two_byte), 8'(two));
    end
    chk_n(nfl, e_fl);
    chk_n(npool, e_fl);
    chk_n(nrep, e_rep);
    chk_n(next, e_ext);
    if (e_ext != 0)
      chk_v(creg, c);
    chk_n(nrme, int'(st));
    chk_n(int'(nw > 0), int'(st));
    if (st)
      chk_v({6'h00, lstat[5], lstat[4]}, {6'h00, bad});
    chk_n(nrpf, st ? nd / 32 : 0);
    chk_n(exq.size(), 0);
    exq.delete();
  endtask
  // about 40 frames of well under 500 cycles each
  initial
  begin
    #(40 * 40000);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end
  initial
  begin
    void'($urandom(32'h093de04e));
    tx1 = 8'($urandom);
    tx2 = 8'($urandom);
    rd = 8'($urandom % 160);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    frame(2'h0, la, 8'h11, rd, 0, 2'h0);
    load(1'b0);
    repeat (2) frame(2'h0, la, 8'h11, rd, 0, 2'h0);
    frame(2'h0, la, 8'h01, rd, 0, 2'h0);
    ar = 1'b1;
    load(1'b0);
    repeat (2) frame(2'h0, la, 8'h11, rd, 0, 2'h0);
    frame(2'h0, la, 8'h01, rd, 0, 2'h0);
    ar = 1'b0;
    frame(2'h0, la, 8'h03, rd, 0, 2'h0);
    frame(2'h0, la, 8'h10, rd, 1, 2'h0);
    frame(2'h0, la, 8'h00, 8'hF5, 2, 2'h0);
    frame(2'h0, la, 8'h10, 8'hB7, 1, 2'h0);
    frame(2'h0, la, 8'h10, rd, 1, 2'h2);
    frame(2'h0, la, 8'h10, rd, 1, 2'h1);
    frame(2'h0, la, 8'h10, 8'hD3, 1, 2'h0);
    frame(2'h0, la, 8'h10, 8'hA2, 1, 2'h0);
    load(1'b1);
    frame(2'h0, la, 8'h10, 8'hA5, 1, 2'h0);
    frame(2'h0, la, 8'h00, 8'hE0, 1, 2'h0);
    frame(2'h0, lb, 8'h10, rd, 1, 2'h0);
    frame(2'h0, 8'h99, 8'h10, rd, 1, 2'h0);
    for (int m = 1; m < 4; m++)
    begin
      frame(2'(m), lb, 8'h10, rd, 1, 2'h0);
      frame(2'(m), 8'hFC, 8'h10, rd, 1, 2'h0);
      frame(2'(m), 8'hFE, 8'h10, rd, 1, 2'h0);
      frame(2'(m), hb, 8'h10, rd, 1, 2'h0);
    end
    two = 1'b1;
    hadr = ha;
    frame(2'h0, la, 8'h11, rd, 0, 2'h0);
    hadr = 8'hFE;
    frame(2'h0, la, 8'h10, rd, 1, 2'h0);
    frame(2'h1, lb, 8'h10, rd, 1, 2'h0);
    hadr = 8'h99;
    frame(2'h1, la, 8'h10, rd, 1, 2'h0);
    two = 1'b0;
    hold = 1'b1;
    fork
      frame(2'h1, la, 8'h10, 8'h40, 40, 2'h0);
      begin
        for (int i = 0; i < 200 && rxr !== 1'b0; i++)
          @(negedge clk);
        chk_n(int'(rxr === 1'b0), 1);
        hold = 1'b0;
      end
    join
    test_done;
  end
endmodule
